// [src/efc_pkg.sv]
package efc_pkg;

  localparam int CMD_W = 32;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 24;
  localparam int CNT_W = 5;
  localparam int NCHAN = 3;

  // Serial word layout
  localparam int CMD_RW_POS = 31;
  localparam int CMD_ADDR_HI = 30;
  localparam int CMD_ADDR_LO = 24;
  localparam int CMD_DATA_HI = 23;

  // Register map
  localparam logic [ADDR_W-1:0] ADDR_NOP = 7'h00;
  localparam logic [ADDR_W-1:0] ADDR_MAIN_CTRL = 7'h01;
  localparam logic [DATA_W-1:0] MAIN_CTRL_RST = 24'h00_0000;
  localparam logic [DATA_W-1:0] MAIN_CTRL_WMASK = 24'hE0_07FE;
  localparam logic [DATA_W-1:0] RD_UNMAPPED = 24'h00_0000;
  localparam logic [CMD_W-1:0] RESP_RST = 32'h0000_0000;

  // Field positions in ecg_main_control
  localparam int LEFT_ARM_CHANNEL_ON_POS = 23;
  localparam int LEFT_LEG_CHANNEL_ON_POS = 22;
  localparam int RIGHT_ARM_CHANNEL_ON_POS = 21;
  localparam int INPUT_CONFIG_SELECT_POS = 10;
  localparam int GAIN_HI = 9;
  localparam int GAIN_LO = 8;
  localparam int REFERENCE_BUFFER_ON_POS = 7;
  localparam int EXTERNAL_CLOCK_SELECT_POS = 6;
  localparam int GANG_MASTER_POS = 5;
  localparam int GANG_ON_POS = 4;
  localparam int HIGH_PERFORMANCE_SEL_POS = 3;
  localparam int CONVERSION_ON_POS = 2;
  localparam int POWER_ON_POS = 1;
  localparam int SOFT_RESET_REQUEST_POS = 0;

  localparam logic [CNT_W-1:0] LAST_BIT = 5'h1F;

  typedef struct packed {
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } efc_cmd_t;

  typedef struct packed {
    logic [NCHAN-1:0] chan_power;
    logic [NCHAN-1:0] chan_hiz;
    logic diff_input;
    logic [1:0] gain;
    logic refbuf;
    logic adc_2msps;
    logic conv_run;
    logic analog_power;
  } efc_afe_t;

  localparam efc_afe_t AFE_RST = '{chan_power: 3'h0, chan_hiz: 3'h7, diff_input: 1'b0,
    gain: 2'h0, refbuf: 1'b0, adc_2msps: 1'b0, conv_run: 1'b0, analog_power: 1'b0};

  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_RST_WAIT = 2'b10
  } efc_state_t;

endpackage

// [src/efc_ctrl_top.sv]
`timescale 1ns/1ps
module efc_ctrl_top
  import efc_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe_n,
  output efc_afe_t afe,
  output logic xtal_on,
  output logic ext_clk_sel,
  output logic clk_io_active,
  output logic clk_io_oe_n,
  output logic sync_gang_oe_n,
  output logic reset_pending
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding shared by write and read paths
  function automatic logic addr_hit(input efc_cmd_t c, input logic [ADDR_W-1:0] a);
    addr_hit = (c.addr == a);
  endfunction

  function automatic logic [DATA_W-1:0] rd_data(input efc_cmd_t c,
                                               input logic [DATA_W-1:0] ctl);
    if (addr_hit(c, ADDR_MAIN_CTRL)) begin
      rd_data = ctl;
    end else begin
      rd_data = RD_UNMAPPED;
    end
  endfunction

  // Channel index to its enable bit; index 2 is the left arm
  function automatic int chan_pos(input int idx);
    case (idx)
      0: chan_pos = RIGHT_ARM_CHANNEL_ON_POS;
      1: chan_pos = LEFT_LEG_CHANNEL_ON_POS;
      default: chan_pos = LEFT_ARM_CHANNEL_ON_POS;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Link domain, runs on the serial clock
  // Clock idles high: drive on falling, sample on rising
  logic [CNT_W-1:0] bit_cnt_q;
  logic [CMD_W-2:0] shift_q;
  logic [CMD_W-1:0] cap_q;
  logic done_q;
  logic [CMD_W-1:0] tx_q;
  logic sdo_q;
  logic sdo_oe_n_q;
  logic [CMD_W-1:0] resp_q;

  // Frame select clears the bit position between words
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt_q <= '0;
    end else begin
      bit_cnt_q <= bit_cnt_q + 5'h01;
    end
  end

  // Data arrives most significant bit first
  always_ff @(posedge sclk) begin
    shift_q <= {shift_q[CMD_W-3:0], sdi};
  end

  // Word held stable until the next frame's last bit
  // Only the first word of an overlong frame counts
  always_ff @(posedge sclk) begin
    if (!cs_n && !done_q && bit_cnt_q == LAST_BIT) begin
      cap_q <= {shift_q, sdi};
    end
  end

  // Level rises on the last bit and stands until frame ends; its rise crosses as a request
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      done_q <= 1'b0;
    end else if (bit_cnt_q == LAST_BIT) begin
      done_q <= 1'b1;
    end
  end

  // Response word changes only between frames, so it is read here directly
  always_ff @(negedge sclk) begin
    if (bit_cnt_q == '0) begin
      tx_q <= {resp_q[CMD_W-2:0], 1'b0};
    end else begin
      tx_q <= {tx_q[CMD_W-2:0], 1'b0};
    end
  end

  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      sdo_q <= 1'b0;
      sdo_oe_n_q <= 1'b1;
    end else begin
      sdo_oe_n_q <= 1'b0;
      if (done_q) begin
        sdo_q <= 1'b0;
      end else if (bit_cnt_q == '0) begin
        sdo_q <= resp_q[CMD_W-1];
      end else begin
        sdo_q <= tx_q[CMD_W-1];
      end
    end
  end

  assign sdo = sdo_q;
  assign sdo_oe_n = sdo_oe_n_q;

  ////////////////////////////////////////////////////////////////////////////
  // Crossing of the frame-done level into the system clock
  logic done_s1_q;
  logic done_s2_q;
  logic done_s3_q;
  logic word_rx;
  efc_cmd_t cmd;

  always_ff @(posedge clk) begin
    if (srst) begin
      done_s1_q <= 1'b0;
      done_s2_q <= 1'b0;
      done_s3_q <= 1'b0;
    end else begin
      done_s1_q <= done_q;
      done_s2_q <= done_s1_q;
      done_s3_q <= done_s2_q;
    end
  end

  assign word_rx = done_s2_q & ~done_s3_q;
  assign cmd = efc_cmd_t'(cap_q);

  ////////////////////////////////////////////////////////////////////////////
  // Soft reset sequencing
  efc_state_t state_q;
  logic [DATA_W-1:0] ctrl_q;
  logic wr_main;
  logic nop_seen;

  // Writes during a pending reset are dropped
  assign wr_main = word_rx & cmd.wr & addr_hit(cmd, ADDR_MAIN_CTRL) & (state_q == ST_RUN);
  assign nop_seen = word_rx & ~cmd.wr & addr_hit(cmd, ADDR_NOP);

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= ST_RUN;
    end else begin
      case (state_q)
        ST_RUN: begin
          if (wr_main && cmd.data[SOFT_RESET_REQUEST_POS]) begin
            state_q <= ST_RST_WAIT;
          end
        end
        ST_RST_WAIT: begin
          if (nop_seen) begin
            state_q <= ST_RUN;
          end
        end
        default: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main control register
  // Reserved bits and the reset request never store, so they read zero
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_q <= MAIN_CTRL_RST;
    end else if (wr_main) begin
      if (cmd.data[SOFT_RESET_REQUEST_POS]) begin
        ctrl_q <= MAIN_CTRL_RST;
      end else begin
        ctrl_q <= cmd.data & MAIN_CTRL_WMASK;
      end
    end
  end

  // Read answer goes out in the following frame
  always_ff @(posedge clk) begin
    if (srst) begin
      resp_q <= RESP_RST;
    end else if (word_rx) begin
      if (!cmd.wr) begin
        resp_q <= {1'b0, cmd.addr, rd_data(cmd, ctrl_q)};
      end else begin
        resp_q <= RESP_RST;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoded controls toward the analog front end
  logic pwr;
  logic gang;
  logic master;
  logic slave;
  logic [NCHAN-1:0] chan_en;

  // Power-down only gates outputs; the register keeps its value
  assign pwr = ctrl_q[POWER_ON_POS];
  assign gang = ctrl_q[GANG_ON_POS];
  assign master = gang & ctrl_q[GANG_MASTER_POS];
  assign slave = gang & ~ctrl_q[GANG_MASTER_POS];
  // One enable per channel, same order as the afe vectors
  for (genvar g = 0; g < NCHAN; g++) begin : g_chan
    assign chan_en[g] = ctrl_q[chan_pos(g)];
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      afe <= AFE_RST;
    end else begin
      afe.chan_power <= chan_en & {NCHAN{pwr}};
      afe.chan_hiz <= ~(chan_en & {NCHAN{pwr}});
      afe.diff_input <= ctrl_q[INPUT_CONFIG_SELECT_POS];
      afe.gain <= ctrl_q[GAIN_HI:GAIN_LO];
      afe.refbuf <= ctrl_q[REFERENCE_BUFFER_ON_POS] & pwr;
      afe.adc_2msps <= ctrl_q[HIGH_PERFORMANCE_SEL_POS];
      afe.conv_run <= ctrl_q[CONVERSION_ON_POS] & pwr;
      afe.analog_power <= pwr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock source and gang pins
  // A gang slave must follow the master clock whatever the select bit says
  always_ff @(posedge clk) begin
    if (srst) begin
      ext_clk_sel <= 1'b0;
    end else begin
      ext_clk_sel <= ctrl_q[EXTERNAL_CLOCK_SELECT_POS] | slave;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      xtal_on <= 1'b0;
    end else begin
      xtal_on <= pwr & ~ctrl_q[EXTERNAL_CLOCK_SELECT_POS] & ~slave;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      clk_io_active <= 1'b0;
    end else begin
      clk_io_active <= gang;
    end
  end

  // Clock pin drives only for a master not selecting the external clock, even while powered down
  always_ff @(posedge clk) begin
    if (srst) begin
      clk_io_oe_n <= 1'b1;
    end else begin
      clk_io_oe_n <= ~(master & ~ctrl_q[EXTERNAL_CLOCK_SELECT_POS]);
    end
  end

  // A slave only listens on the sync pin
  always_ff @(posedge clk) begin
    if (srst) begin
      sync_gang_oe_n <= 1'b1;
    end else begin
      sync_gang_oe_n <= ~master;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      reset_pending <= 1'b0;
    end else begin
      reset_pending <= (state_q == ST_RST_WAIT);
    end
  end

endmodule // efc_ctrl_top

// [tb/efc_ctrl_props.sv]
`timescale 1ns/1ps
module efc_ctrl_props
  import efc_pkg::*;
(
  input logic clk,
  input logic srst,
  input logic sclk,
  input logic cs_n,
  input logic sdi,
  input logic sdo,
  input logic sdo_oe_n,
  input efc_afe_t afe,
  input logic xtal_on,
  input logic ext_clk_sel,
  input logic clk_io_active,
  input logic clk_io_oe_n,
  input logic sync_gang_oe_n,
  input logic reset_pending
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////
  chan_hiz_a: assert property (afe.chan_hiz == ~afe.chan_power)
    else $error("channel high-Z wrong");
  power_gate_a: assert property (!afe.analog_power |->
    afe.chan_power == 3'h0 && !afe.refbuf && !afe.conv_run && !xtal_on)
    else $error("analog alive while powered down");
  soft_clear_a: assert property ($rose(reset_pending) |->
    afe.chan_power == 3'h0 && !afe.analog_power && !afe.diff_input && afe.gain == 2'h0)
    else $error("soft reset left fields set");
  clk_pick_a: assert property (xtal_on |-> !ext_clk_sel)
    else $error("two clock sources");
  slave_clk_a: assert property (clk_io_active && sync_gang_oe_n |->
    ext_clk_sel && !xtal_on)
    else $error("slave kept crystal");
  master_pin_a: assert property (!sync_gang_oe_n |-> clk_io_active)
    else $error("sync driven outside gang");
  gang_off_a: assert property (!clk_io_active |-> clk_io_oe_n && sync_gang_oe_n)
    else $error("gang pin driven");
  sdo_idle_a: assert property (cs_n |-> sdo_oe_n && !sdo)
    else $error("sdo driven outside frame");
  ////////////////////////////////////////
  cover property ($rose(reset_pending));
  cover property (!sync_gang_oe_n);
  cover property (clk_io_active && sync_gang_oe_n);
endmodule // efc_ctrl_props

bind efc_ctrl_top efc_ctrl_props i_efc_ctrl_props(.clk(clk), .srst(srst), .sclk(sclk),
  .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n), .afe(afe), .xtal_on(xtal_on),
  .ext_clk_sel(ext_clk_sel), .clk_io_active(clk_io_active), .clk_io_oe_n(clk_io_oe_n),
  .sync_gang_oe_n(sync_gang_oe_n), .reset_pending(reset_pending));

// [tb/efc_host_model.sv]
`timescale 1ns/1ps
module efc_host_model (
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input logic sdo
);
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    sdi = 1'b0;
  end
  // Idle high, clock stops between frames
  task automatic xfer(input logic [31:0] w, output logic [31:0] r);
    cs_n = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      #32 sclk = 1'b0;
      sdi = w[i];
      #32 sclk = 1'b1;
      r[i] = sdo;
    end
    #300 cs_n = 1'b1;
    // Released line, no stale level to lean on
    sdi = ~sdi;
    #300;
  endtask
endmodule // efc_host_model

// [tb/test_efc_ctrl_top.sv]
`timescale 1ns/1ps
module test_efc_ctrl_top
  import efc_pkg::*;
;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic sclk, cs_n, sdi, sdo, sdo_oe_n, xtal_on, ext_clk_sel, clk_io_active;
  logic clk_io_oe_n, sync_gang_oe_n, reset_pending;
  efc_afe_t afe;
  logic [31:0] res, prev, r;
  logic [31:0] q[$];
  logic [23:0] c, d;
  integer seed = 32'hf988;
  int errors = 0;
  int n_tests = 0;
  event got;
  always #25 clk = ~clk;
  efc_host_model i_efc_host_model(.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));
  efc_ctrl_top i_efc_ctrl_top(.clk(clk), .srst(srst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .sdo(sdo), .sdo_oe_n(sdo_oe_n), .afe(afe), .xtal_on(xtal_on), .ext_clk_sel(ext_clk_sel),
    .clk_io_active(clk_io_active), .clk_io_oe_n(clk_io_oe_n),
    .sync_gang_oe_n(sync_gang_oe_n), .reset_pending(reset_pending));
  ////////////////////////////////////////
  task automatic summarize;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  function automatic logic [31:0] pins(input logic [23:0] v, input logic p);
    logic w, g, m, s;
    w = v[1];
    g = v[4];
    m = v[5];
    s = g & ~m;
    pins = {13'h0, v[23:21] & {3{w}}, ~(v[23:21] & {3{w}}), v[10], v[9:8], v[7] & w, v[3],
      v[2] & w, w, w & ~v[6] & ~s, v[6] | s, g, ~(g & m & ~v[6]), ~(g & m), p};
  endfunction
  // Read answers come one frame late
  task automatic frame(input logic [31:0] w);
    q.push_back(prev);
    i_efc_host_model.xfer(w, r);
    res = r;
    ->got;
    prev = w[31] ? 32'h0 : {1'b0, w[30:24], (w[30:24] == ADDR_MAIN_CTRL) ? c : 24'h0};
  endtask
  task automatic look(input logic p);
    @(negedge clk);
    q.push_back(pins(c, p));
    res = {13'h0, afe, xtal_on, ext_clk_sel, clk_io_active, clk_io_oe_n, sync_gang_oe_n,
      reset_pending};
    ->got;
  endtask
  ////////////////////////////////////////
  initial forever begin
    @got;
    n_tests++;
    if (res !== q[0]) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, res, q[0]);
    end
    void'(q.pop_front());
  end
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    summarize;
  end
  initial begin
    prev = 32'h0;
    c = 24'h0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    look(1'b0);
    for (int i = 0; i < 16; i++) begin
      d = 24'($random(seed));
      d[0] = 1'b0;
      d[9:8] = i[1:0];
      d[6:4] = i[3:1];
      c = d & MAIN_CTRL_WMASK;
      frame({1'b1, ADDR_MAIN_CTRL, d});
      look(1'b0);
      frame({1'b0, ADDR_MAIN_CTRL, d});
    end
    frame({1'b0, 7'h05, 24'hFF_FFFF});
    frame({1'b0, 7'h7F, 24'h00_0000});
    c = MAIN_CTRL_WMASK;
    frame({1'b1, ADDR_MAIN_CTRL, 24'hFF_FFFE});
    look(1'b0);
    c = 24'h00_0000;
    frame({1'b1, ADDR_MAIN_CTRL, 24'hFF_FFFF});
    look(1'b1);
    frame({1'b1, ADDR_MAIN_CTRL, 24'h00_0002});
    look(1'b1);
    frame({1'b0, ADDR_MAIN_CTRL, 24'h00_0000});
    frame({1'b0, ADDR_NOP, 24'h00_0000});
    look(1'b0);
    c = 24'h00_0000;
    frame({1'b1, ADDR_MAIN_CTRL, 24'h00_0003});
    look(1'b1);
    frame({1'b0, ADDR_MAIN_CTRL, 24'h00_0000});
    frame({1'b0, ADDR_NOP, 24'h00_0000});
    look(1'b0);
    c = 24'h00_0002;
    frame({1'b1, ADDR_MAIN_CTRL, 24'h00_0002});
    look(1'b0);
    frame({1'b0, ADDR_MAIN_CTRL, 24'h00_0000});
    frame({1'b0, ADDR_NOP, 24'h00_0000});
    repeat (2) @(posedge clk);
    summarize;
  end
endmodule // test_efc_ctrl_top
